//--- iatc_pkg.sv
// shared constants and types of the image acquisition trigger control block
`default_nettype none
package iatc_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS     = 25;
  localparam int US_NS             = 1000;
  localparam int US_CYCLES         = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_WINDOW_US_DEF = 1000000;
  localparam int FRAME_BUDGET_US   = 1000000;
  // exposure limits in microseconds, auto integration tuning and the device-picked frame rate
  localparam int INTEG_W           = 25;
  localparam logic [INTEG_W-1:0] INTEG_MIN_US = 25'h000001D;
  localparam logic [INTEG_W-1:0] INTEG_MAX_US = 25'h1C9C380;
  localparam logic [INTEG_W-1:0] INTEG_RST_US = 25'h00003E8;
  localparam logic [INTEG_W-1:0] AUTO_STEP_US = 25'h0000010;
  localparam logic [7:0]  AUTO_TARGET_LEVEL  = 8'h80;
  localparam logic [7:0]  AUTO_TOLERANCE     = 8'h08;
  localparam logic [3:0]  AUTO_ONCE_FRAMES   = 4'h8;
  localparam logic [15:0] AUTO_RATE_HZ       = 16'h003C;
  // capture run modes
  localparam logic [1:0] RUN_CONT   = 2'h0;
  localparam logic [1:0] RUN_BURST  = 2'h1;
  localparam logic [1:0] RUN_SINGLE = 2'h2;
  localparam logic [1:0] RUN_RST    = 2'h0;
  // automatic integration settings
  localparam logic [1:0] AUTO_OFF  = 2'h0;
  localparam logic [1:0] AUTO_ONCE = 2'h1;
  localparam logic [1:0] AUTO_CONT = 2'h2;
  localparam logic [1:0] AUTO_RST  = 2'h0;
  // integration control modes
  localparam logic INTEG_TIMED = 1'h0;
  localparam logic INTEG_WIDTH = 1'h1;
  // trigger kinds, origins and polarities
  localparam logic KIND_RUN   = 1'h0;
  localparam logic KIND_FRAME = 1'h1;
  localparam logic [2:0] ORIGIN_SOFT = 3'h7;
  localparam logic [2:0] ORIGIN_RST  = 3'h0;
  localparam logic [1:0] POL_LOW  = 2'h0;
  localparam logic [1:0] POL_HIGH = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;
  localparam logic [1:0] POL_RISE = 2'h3;
  localparam logic [1:0] POL_RST  = 2'h3;
  localparam logic GATE_RST = 1'h0;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE       = 2'h0,
    ST_ARM        = 2'h1,
    ST_WAIT_FRAME = 2'h2,
    ST_EXPOSE     = 2'h3
  } iatc_state_t;
endpackage : iatc_pkg
`default_nettype wire

//--- iatc_core.sv
// capture sequencer, frame pacing, integration control and trigger gating
//
// Notes on behaviour
// - three run modes; continuous after reset, capturing without limit
// - burst mode captures burst_image_count images (one when it is zero), then ends the run
// - single mode captures one image, then ends the run itself
// - begin and end commands bracket a run in the selected mode
// - manual rate paces at target rate; else device picks; manual off at reset
// - achieved rate reports delivered frames; drops when exposure exceeds period
// - pulse width mode: exposure lasts while the trigger is active
// - timed mode with auto off exposes for integration_duration_us
// - auto once adapts for a few frames, then returns to off
// - auto continuous keeps adapting exposure every frame
// - trigger gating off after reset; triggers honoured only when gated on
// - kind select picks which trigger kind the settings apply to
// - run-start trigger begins a run in the selected mode
// - per-frame trigger in single or burst needs a new begin per trigger
// - per-frame trigger in continuous captures one image per trigger
// - trigger taken from chosen input line or the software command
// - detect trigger by low level, high level, falling or rising edge
// - software command triggers only when the origin is software
`timescale 1ns/1ps
`default_nettype none
module iatc_core
  import iatc_pkg::*;
#(
  parameter int NLINES         = 4,
  parameter int CNT_W          = 16,
  parameter int RATE_W         = 16,
  parameter int RATE_WINDOW_US = RATE_WINDOW_US_DEF
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // run control
  input  wire logic [1:0]         capture_run_mode,
  input  wire logic [CNT_W-1:0]   burst_image_count,
  input  wire logic               begin_capture_command,
  input  wire logic               end_capture_command,
  // frame rate
  input  wire logic               manual_rate_select,
  input  wire logic [RATE_W-1:0]  target_image_rate,
  // integration
  input  wire logic               integration_control_mode,
  input  wire logic [INTEG_W-1:0] integration_duration_us,
  input  wire logic               integration_write,
  input  wire logic [1:0]         auto_integration_setting,
  input  wire logic               auto_integration_write,
  input  wire logic [7:0]         scene_level,
  // trigger configuration
  input  wire logic               trigger_kind_select,
  input  wire logic               trigger_cfg_write,
  input  wire logic               trigger_gate,
  input  wire logic [2:0]         trigger_origin_select,
  input  wire logic [1:0]         trigger_polarity_select,
  input  wire logic               soft_trigger_command,
  input  wire logic [NLINES-1:0]  trigger_lines,
  // status
  output logic                    capture_running,
  output logic                    exposure_active,
  output logic                    frame_done,
  output logic [CNT_W-1:0]        images_captured,
  output logic [RATE_W-1:0]       achieved_image_rate,
  output logic [INTEG_W-1:0]      integration_now_us,
  output logic [1:0]              auto_integration_state
);

  iatc_state_t state;
  iatc_state_t next_state;
  logic              done_now;
  logic [NLINES-1:0] line_meta;
  logic [NLINES-1:0] line_sync;
  wire  [1:0]        gate_v;
  wire  [1:0]        trig_evt;
  wire  [1:0]        lvl_act;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_meta <= '0;
      line_sync <= '0;
    end else begin
      line_meta <= trigger_lines;
      line_sync <= line_meta;
    end
  end

  for (genvar k = 0; k < 2; k++) begin : g_kind
    logic       gate;
    logic [2:0] origin;
    logic [1:0] pol;
    logic       prev_lvl;
    logic       evt;
    logic       soft_hit;
    logic       lvl;
    logic       hit;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        gate   <= GATE_RST;
        origin <= ORIGIN_RST;
        pol    <= POL_RST;
      end else if (trigger_cfg_write && (trigger_kind_select == k[0])) begin
        gate   <= trigger_gate;
        origin <= trigger_origin_select;
        pol    <= trigger_polarity_select;
      end
    end
    // software command counts only for a software origin
    assign soft_hit = soft_trigger_command && (trigger_kind_select == k[0]) && (origin == ORIGIN_SOFT);
    assign lvl = (origin == ORIGIN_SOFT) ? soft_hit :
                 (int'(origin) < NLINES) ? line_sync[origin[$clog2(NLINES)-1:0]] : 1'b0;
    always_comb begin
      hit = 1'b0;
      case (pol)
        POL_LOW:  hit = !lvl;
        POL_HIGH: hit = lvl;
        POL_FALL: hit = prev_lvl && !lvl;
        POL_RISE: hit = !prev_lvl && lvl;
        default:  hit = 1'b0;
      endcase
      if (origin == ORIGIN_SOFT) begin
        hit = soft_hit;
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        prev_lvl <= 1'b0;
        evt      <= 1'b0;
      end else begin
        prev_lvl <= lvl;
        evt      <= gate && hit;
      end
    end
    assign gate_v[k]   = gate;
    assign trig_evt[k] = evt;
    assign lvl_act[k]  = (origin == ORIGIN_SOFT) ? soft_hit :
                         ((pol == POL_LOW) || (pol == POL_FALL)) ? !lvl : lvl;
  end

  // run and frame trigger roles
  logic frame_trig_mode;
  logic run_trig_needed;
  logic run_trig;
  logic exp_level;
  assign frame_trig_mode = gate_v[KIND_FRAME] && (capture_run_mode == RUN_CONT);
  assign run_trig_needed = gate_v[KIND_RUN] || (gate_v[KIND_FRAME] && (capture_run_mode != RUN_CONT));
  assign run_trig = (gate_v[KIND_RUN] && trig_evt[KIND_RUN]) ||
                    (gate_v[KIND_FRAME] && (capture_run_mode != RUN_CONT) && trig_evt[KIND_FRAME]);
  assign exp_level = gate_v[KIND_FRAME] ? lvl_act[KIND_FRAME] : lvl_act[KIND_RUN];

  // microsecond tick and frame pacing accumulator
  logic [5:0]  us_div;
  logic        us_tick;
  logic [20:0] pace_acc;
  logic [20:0] pace_sum;
  logic        pace_pending;
  logic [RATE_W-1:0] rate_now;
  assign us_tick  = (us_div == 6'(US_CYCLES - 1));
  assign rate_now = manual_rate_select ? target_image_rate : RATE_W'(AUTO_RATE_HZ);
  assign pace_sum = pace_acc + 21'(rate_now);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      us_div   <= '0;
      pace_acc <= '0;
    end else begin
      us_div <= us_tick ? 6'h00 : us_div + 6'h01;
      if (us_tick) begin
        pace_acc <= (pace_sum >= 21'(FRAME_BUDGET_US)) ? pace_sum - 21'(FRAME_BUDGET_US) : pace_sum;
      end
    end
  end

  // a pacing slot not used yet stays pending; a new slot wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pace_pending <= 1'b1;
    end else if (state == ST_IDLE) begin
      pace_pending <= 1'b1;
    end else if (us_tick && (pace_sum >= 21'(FRAME_BUDGET_US))) begin
      pace_pending <= 1'b1;
    end else if (next_state == ST_EXPOSE && state != ST_EXPOSE) begin
      pace_pending <= 1'b0;
    end
  end

  // exposure timing
  logic [5:0]         exp_div;
  logic [INTEG_W-1:0] exp_us;
  logic               exp_over;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exp_div <= '0;
      exp_us  <= '0;
    end else if (state != ST_EXPOSE) begin
      exp_div <= 6'h01; // entry cycle counts, so the exposure lasts exactly the set microseconds
      exp_us  <= integration_now_us;
    end else if (exp_div == 6'(US_CYCLES - 1)) begin
      exp_div <= '0;
      exp_us  <= (exp_us != '0) ? exp_us - 1'b1 : exp_us;
    end else begin
      exp_div <= exp_div + 6'h01;
    end
  end
  // timed length; trigger width ends it
  assign exp_over = (integration_control_mode == INTEG_WIDTH) ? !exp_level : (exp_us == '0);

  logic [CNT_W:0] run_total;
  logic [CNT_W:0] count_next;
  assign run_total  = (capture_run_mode == RUN_SINGLE) ? (CNT_W+1)'(1) :
                      (burst_image_count == '0) ? (CNT_W+1)'(1) : {1'b0, burst_image_count};
  assign count_next = {1'b0, images_captured} + 1'b1;

  always_comb begin
    next_state = state;
    done_now   = 1'b0;
    case (state)
      // begin, waiting for a run trigger if gated
      ST_IDLE: if (begin_capture_command) begin
        next_state = run_trig_needed ? ST_ARM : ST_WAIT_FRAME;
      end
      // per-frame trigger in counted modes starts the set
      ST_ARM: if (run_trig) begin
        next_state = ST_WAIT_FRAME;
      end
      // continuous per-frame trigger takes one image each
      ST_WAIT_FRAME: if (pace_pending && (!frame_trig_mode || trig_evt[KIND_FRAME])) begin
        next_state = ST_EXPOSE;
      end
      // end counted runs at their total
      ST_EXPOSE: if (exp_over) begin
        done_now   = 1'b1;
        next_state = ((capture_run_mode != RUN_CONT) && (count_next >= run_total)) ? ST_IDLE : ST_WAIT_FRAME;
      end
      default: next_state = ST_IDLE;
    endcase
    // stop command aborts the run, including a running exposure
    if (end_capture_command) begin
      next_state = ST_IDLE;
      done_now   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state           <= ST_IDLE;
      capture_running <= 1'b0;
      exposure_active <= 1'b0;
      frame_done      <= 1'b0;
    end else begin
      state           <= next_state;
      capture_running <= (next_state != ST_IDLE);
      exposure_active <= (next_state == ST_EXPOSE);
      frame_done      <= done_now;
    end
  end

  // images counted per run, cleared on begin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      images_captured <= '0;
    end else if (state == ST_IDLE && begin_capture_command) begin
      images_captured <= '0;
    end else if (done_now) begin
      images_captured <= count_next[CNT_W-1:0];
    end
  end

  logic [20:0]       win_us;
  logic [RATE_W-1:0] win_frames;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_us              <= '0;
      win_frames          <= '0;
      achieved_image_rate <= '0;
    end else if (us_tick && (win_us == 21'(RATE_WINDOW_US - 1))) begin
      win_us              <= '0;
      win_frames          <= '0;
      achieved_image_rate <= win_frames + RATE_W'(done_now);
    end else begin
      win_us     <= us_tick ? win_us + 21'h000001 : win_us;
      win_frames <= win_frames + RATE_W'(done_now);
    end
  end

  // automatic integration setting and its self-return to off
  logic [3:0] once_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auto_integration_state <= AUTO_RST;
      once_cnt               <= '0;
    end else if (auto_integration_write) begin
      auto_integration_state <= auto_integration_setting;
      once_cnt               <= '0;
    end else if (frame_done && auto_integration_state == AUTO_ONCE) begin
      once_cnt <= once_cnt + 4'h1;
      if (once_cnt == AUTO_ONCE_FRAMES - 4'h1) begin
        auto_integration_state <= AUTO_OFF;
      end
    end
  end

  // adaptation steps toward the target scene level, kept within exposure limits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      integration_now_us <= INTEG_RST_US;
    end else if (auto_integration_state == AUTO_OFF) begin
      if (integration_write) begin
        integration_now_us <= integration_duration_us;
      end
    end else if (frame_done) begin
      if (scene_level < AUTO_TARGET_LEVEL - AUTO_TOLERANCE && integration_now_us < INTEG_MAX_US - AUTO_STEP_US) begin
        integration_now_us <= integration_now_us + AUTO_STEP_US;
      end else if (scene_level > AUTO_TARGET_LEVEL + AUTO_TOLERANCE &&
                   integration_now_us > INTEG_MIN_US + AUTO_STEP_US) begin
        integration_now_us <= integration_now_us - AUTO_STEP_US;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_single_ends: assert property (
    frame_done && $past(capture_run_mode) == RUN_SINGLE |-> !capture_running)
    else $error("single run did not end after one image");
  a_burst_ends: assert property (
    frame_done && $past(capture_run_mode) == RUN_BURST && images_captured == $past(burst_image_count)
    |-> !capture_running)
    else $error("burst run did not end at its count");
  a_cont_keeps: assert property (
    frame_done && $past(capture_run_mode) == RUN_CONT && !$past(end_capture_command) |-> capture_running)
    else $error("continuous run ended on its own");
  a_end_stops: assert property (
    end_capture_command |=> !capture_running && !exposure_active && !frame_done)
    else $error("end command did not stop the run");
  a_pace_start: assert property (
    state == ST_WAIT_FRAME && pace_pending && !frame_trig_mode && !end_capture_command |=> exposure_active)
    else $error("paced frame did not start");
  a_width_follow: assert property (
    state == ST_EXPOSE && integration_control_mode == INTEG_WIDTH && !exp_level && !end_capture_command
    |=> !exposure_active ##0 frame_done)
    else $error("width exposure outlived its trigger");
  a_once_returns: assert property (
    auto_integration_state == AUTO_ONCE && frame_done && once_cnt == AUTO_ONCE_FRAMES - 4'h1 &&
    !auto_integration_write |=> auto_integration_state == AUTO_OFF)
    else $error("auto once did not return to off");
  a_edge_pulse: assert property (
    trig_evt[KIND_FRAME] && g_kind[1].origin != ORIGIN_SOFT && g_kind[1].pol[1] &&
    $stable(g_kind[1].pol) |=> !trig_evt[KIND_FRAME])
    else $error("edge trigger event longer than one cycle");
  a_gate_blocks: assert property (
    !gate_v[KIND_RUN] && !gate_v[KIND_FRAME] && state == ST_IDLE && begin_capture_command &&
    !end_capture_command |=> state == ST_WAIT_FRAME)
    else $error("ungated begin waited for a trigger");

  c_burst_run: cover property (frame_done && !capture_running && $past(capture_run_mode) == RUN_BURST);
  c_run_trig:  cover property (state == ST_ARM && run_trig);
  c_frame_trig: cover property (state == ST_WAIT_FRAME && frame_trig_mode && trig_evt[KIND_FRAME]);
  c_once_done: cover property (auto_integration_state == AUTO_ONCE ##1 auto_integration_state == AUTO_OFF);

endmodule : iatc_core
`default_nettype wire

//--- iatc_line_src.sv
// trigger line source standing in for the external trigger wiring
`timescale 1ns/1ps
`default_nettype none
module iatc_line_src (
  // clock
  input  wire logic       clk,
  // requests from the bench
  input  wire logic [1:0] line_sel,
  input  wire logic       act_lvl,
  input  wire logic       fire,
  // physical trigger lines
  output var logic [3:0]  trigger_lines
);
  initial trigger_lines = 4'hF;
  // lines idle inactive, chosen one driven active
  always @(posedge clk) begin
    trigger_lines <= {4{~act_lvl}};
    if (fire) begin
      trigger_lines[line_sel] <= act_lvl;
    end
  end
endmodule : iatc_line_src
`default_nettype wire

//--- tb.sv
// self-checking bench of the acquisition trigger control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iatc_pkg::*;
  logic               clk, nrst, begin_capture_command, end_capture_command, manual_rate_select;
  logic               integration_control_mode, integration_write, auto_integration_write;
  logic               trigger_kind_select, trigger_cfg_write, trigger_gate, soft_trigger_command;
  logic               fire, act_lvl, capture_running, exposure_active, frame_done;
  logic [1:0]         capture_run_mode, auto_integration_setting, trigger_polarity_select;
  logic [1:0]         line_sel, auto_integration_state;
  logic [2:0]         trigger_origin_select;
  logic [3:0]         trigger_lines;
  logic [7:0]         scene_level;
  logic [15:0]        burst_image_count, target_image_rate, images_captured, achieved_image_rate;
  logic [INTEG_W-1:0] integration_duration_us, integration_now_us, prev_us;
  int                 miscompares, checks_done, n, p;

  // short rate window keeps the run brief: rate reads as frames per 100 us
  iatc_core #(.RATE_WINDOW_US(100)) i_dut (
    .clk, .nrst, .capture_run_mode, .burst_image_count, .begin_capture_command, .end_capture_command,
    .manual_rate_select, .target_image_rate, .integration_control_mode, .integration_duration_us,
    .integration_write, .auto_integration_setting, .auto_integration_write, .scene_level,
    .trigger_kind_select, .trigger_cfg_write, .trigger_gate, .trigger_origin_select,
    .trigger_polarity_select, .soft_trigger_command, .trigger_lines, .capture_running,
    .exposure_active, .frame_done, .images_captured, .achieved_image_rate, .integration_now_us,
    .auto_integration_state
  );

  iatc_line_src i_src (.clk, .line_sel, .act_lvl, .fire, .trigger_lines);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // inputs and samples both live on the falling edge, away from the design's edge
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick

  task automatic strobe(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : strobe

  task automatic set_integ(input logic [INTEG_W-1:0] us);
    integration_duration_us = us;
    strobe(integration_write);
  endtask : set_integ

  task automatic cfg_trig(input logic kind, input logic gate, input logic [2:0] org, input logic [1:0] pol);
    trigger_kind_select = kind;
    trigger_gate = gate;
    trigger_origin_select = org;
    trigger_polarity_select = pol;
    strobe(trigger_cfg_write);
  endtask : cfg_trig

  // counts exposing cycles up to the end-of-image pulse; a hang counts as a miss
  task automatic wait_frame(output int cyc);
    int k;
    cyc = 0;
    for (k = 0; k < 20000; k++) begin
      @(negedge clk);
      if (frame_done === 1'b1) break;
      if (exposure_active === 1'b1) cyc++;
    end
    check("frame wait", k < 20000, 1);
  endtask : wait_frame

  initial begin
    #2500000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    {nrst, begin_capture_command, end_capture_command, manual_rate_select, fire, act_lvl} = '0;
    {integration_control_mode, integration_write, auto_integration_write, trigger_kind_select} = '0;
    {trigger_cfg_write, trigger_gate, soft_trigger_command, line_sel} = '0;
    {capture_run_mode, auto_integration_setting, trigger_origin_select} = '0;
    trigger_polarity_select = POL_RISE;
    scene_level = 8'h80;
    burst_image_count = 16'h0003;
    target_image_rate = 16'hC350;
    integration_duration_us = INTEG_RST_US;
    tick(4);
    nrst = 1'b1;
    tick(1);
    check("reset integ", integration_now_us, INTEG_RST_US);
    check("reset auto", auto_integration_state, AUTO_RST);
    check("reset run", capture_running, 0);
    set_integ(25'h0000002);
    tick(1);
    check("integ load", integration_now_us, 2);
    capture_run_mode = RUN_SINGLE;
    strobe(begin_capture_command);
    wait_frame(n);
    check("single expo", n, 2 * US_CYCLES);
    check("single end", capture_running, 0);
    check("single count", images_captured, 1);
    $display("test single done");
    manual_rate_select = 1'b1;
    capture_run_mode = RUN_BURST;
    strobe(begin_capture_command);
    for (p = 1; p <= 3; p++) begin
      wait_frame(n);
      check("burst count", images_captured, p);
    end
    check("burst end", capture_running, 0);
    $display("test burst done");
    capture_run_mode = RUN_CONT;
    strobe(begin_capture_command);
    repeat (5) wait_frame(n);
    check("cont running", capture_running, 1);
    tick(8000);
    check("rate paced", achieved_image_rate inside {[4:5]}, 1);
    set_integ(25'h000001E);
    tick(8000);
    check("rate drops", achieved_image_rate < 16'h0005, 1);
    set_integ(25'h0000002);
    auto_integration_setting = AUTO_ONCE;
    strobe(auto_integration_write);
    tick(1);
    check("auto once", auto_integration_state, AUTO_ONCE);
    repeat (10) wait_frame(n);
    check("once back off", auto_integration_state, AUTO_OFF);
    scene_level = 8'h20;
    auto_integration_setting = AUTO_CONT;
    strobe(auto_integration_write);
    prev_us = integration_now_us;
    repeat (3) wait_frame(n);
    check("auto cont", auto_integration_state, AUTO_CONT);
    check("auto grows", integration_now_us > prev_us, 1);
    strobe(end_capture_command);
    tick(1);
    check("stopped", capture_running, 0);
    auto_integration_setting = AUTO_OFF;
    strobe(auto_integration_write);
    set_integ(25'h0000002);
    $display("test continuous done");
    cfg_trig(KIND_RUN, 1'b1, 3'h0, POL_RISE);
    capture_run_mode = RUN_SINGLE;
    strobe(begin_capture_command);
    tick(20);
    check("armed", {capture_running, exposure_active}, 2'h2);
    strobe(soft_trigger_command);
    tick(10);
    check("soft refused", exposure_active, 0);
    // host picks the software origin before the command
    cfg_trig(KIND_RUN, 1'b1, ORIGIN_SOFT, POL_RISE);
    strobe(soft_trigger_command);
    wait_frame(n);
    check("soft frame", n, 2 * US_CYCLES);
    check("soft end", capture_running, 0);
    cfg_trig(KIND_RUN, 1'b0, ORIGIN_SOFT, POL_RISE);
    $display("test software done");
    line_sel = 2'h2;
    for (p = 0; p < 4; p++) begin
      act_lvl = p[0];
      cfg_trig(KIND_FRAME, 1'b1, 3'h2, p[1:0]);
      tick(8);
      // host issues a begin ahead of each pass's first trigger, none before the second
      strobe(begin_capture_command);
      tick(10);
      check("line armed", exposure_active, 0);
      fire = 1'b1;
      wait_frame(n);
      check("line frame", n, 2 * US_CYCLES);
      fire = 1'b0;
      tick(8);
      fire = 1'b1;
      tick(8);
      fire = 1'b0;
      check("no rerun", capture_running, 0);
    end
    $display("test polarity done");
    capture_run_mode = RUN_CONT;
    strobe(begin_capture_command);
    repeat (2) begin
      fire = 1'b1;
      wait_frame(n);
      fire = 1'b0;
      tick(900);
    end
    check("per frame cont", {capture_running, images_captured}, 17'h10002);
    strobe(end_capture_command);
    $display("test per-frame done");
    integration_control_mode = 1'b1;
    act_lvl = 1'b1;
    cfg_trig(KIND_FRAME, 1'b1, 3'h2, POL_HIGH);
    capture_run_mode = RUN_SINGLE;
    tick(8);
    strobe(begin_capture_command);
    fire = 1'b1;
    tick(200);
    check("width holds", exposure_active, 1);
    fire = 1'b0;
    wait_frame(n);
    check("width ends", n < 8, 1);
    integration_control_mode = 1'b0;
    $display("test width done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
